// ===== remote_cal_pkg.sv
package remote_cal_pkg;
  // register byte offsets on the software port
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h04;
  localparam logic [7:0] OFS_ARG  = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0C;
  localparam logic [7:0] OFS_RX   = 8'h10;
  // control and argument word field positions
  localparam int CTRL_GO      = 8;
  localparam int CTRL_NO_LOAD = 9;
  localparam int CTRL_CLEAR   = 10;
  localparam int ARG_CLEAR    = 8;
  // reset values
  localparam logic [23:0] ADDR_RST = 24'h303031;   // unit address "001"
  localparam logic [9:0]  TX_IDLE  = 10'h3FF;
  // frame characters
  localparam logic [7:0] CH_AT   = 8'h40;
  localparam logic [7:0] CH_HASH = 8'h23;
  localparam logic [7:0] CH_CR   = 8'h0D;
  localparam logic [7:0] CH_LF   = 8'h0A;
  localparam logic [7:0] CH_SP   = 8'h20;
  localparam logic [7:0] CH_0    = 8'h30;
  localparam logic [7:0] CH_1    = 8'h31;
  localparam logic [7:0] CH_9    = 8'h39;
  localparam logic [7:0] CH_A    = 8'h41;
  localparam logic [7:0] CH_B    = 8'h42;
  localparam logic [7:0] CH_DOT  = 8'h2E;
  localparam logic [7:0] CH_MIN  = 8'h2D;
  localparam logic [7:0] CH_PLUS = 8'h2B;
  // field sizes
  localparam int ARG_DEPTH  = 16;
  localparam int SERIAL_MAX = 8;
  localparam int DATE_LEN   = 7;
  localparam int DRIVE_LEN  = 3;
  // timing
  localparam int CLK_HZ       = 100_000_000;
  localparam int BAUD_RATE    = 9600;
  localparam int BIT_CYCLES   = CLK_HZ / BAUD_RATE;
  localparam int SHUNT_TIME_S = 10;
  localparam int SHUNT_CYCLES = SHUNT_TIME_S * CLK_HZ;

  // commands that software may order
  typedef enum logic [4:0] {
    CMD_OUTPUT_QUERY  = 5'h00, CMD_OUTPUT_CONFIG = 5'h01,
    CMD_CHAN_A_GAUGE  = 5'h02, CMD_CHAN_B_GAUGE  = 5'h03,
    CMD_GAUGE_ROLL    = 5'h04, CMD_GAUGE_PICK    = 5'h05,
    CMD_GAUGE_REMOVE  = 5'h06, CMD_TEDS_QUERY    = 5'h07,
    CMD_SHUNT_VERIFY  = 5'h08, CMD_CALIB_ID      = 5'h09,
    CMD_CALIB_DATE    = 5'h0A, CMD_CALIB_DRIVE   = 5'h0B,
    CMD_CALIB_RATING  = 5'h0C, CMD_CALIB_ABORT   = 5'h0D,
    CMD_ONE_POINT_MVV = 5'h0E, CMD_WEIGHT_POINTS = 5'h0F,
    CMD_TORQUE_POINTS = 5'h10, CMD_SHUNT_CAL     = 5'h11
  } cmd_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_LOAD  = 2'b01,
    ST_SHIFT = 2'b10,
    ST_HOLD  = 2'b11
  } tx_state_t;
endpackage

// ===== remote_cal_host.sv
`timescale 1ns/1ps
// Behaviour
// - output config sends item, unit, full-scale '#', zero-scale '#'
// - after cell type change, flag that output config must be resent
// - gauge pick carries channel letter and serial ended by '#'
// - gauge remove carries serial ended by '#'
// - shunt verify only when software confirms cell is unloaded
// - point calibration commands refused before full begin sequence
// - first begin part: space/0/1, channel A/B, serial max 8, '#'
// - second begin part: space then six date digits
// - third begin part: space, excitation 0 or 1, unit code
// - fourth begin part: space, rated value ended by '#'
// - cells calibrated on the channel where they will be used
module remote_cal_host #(
  parameter int BIT_CYCLES   = remote_cal_pkg::BIT_CYCLES,
  parameter int SHUNT_CYCLES = remote_cal_pkg::SHUNT_CYCLES
) (
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  output logic             txd_o,
  input  wire logic        rxd_i
);
  localparam int DEPTH = remote_cal_pkg::ARG_DEPTH;

  // refuse timing the counters cannot hold
  if (BIT_CYCLES < 4 || BIT_CYCLES > 65535 || SHUNT_CYCLES < 1
      || SHUNT_CYCLES > 30'h3FFF_FFFF) begin : g_bad_cfg
    $error("unsupported timing parameters");
  end

  // mnemonic characters per command, last byte 00 when only two long
  function automatic logic [23:0] mnem(input remote_cal_pkg::cmd_t c);
    case (c)
      remote_cal_pkg::CMD_OUTPUT_QUERY:  mnem = 24'h415600;
      remote_cal_pkg::CMD_OUTPUT_CONFIG: mnem = 24'h415300;
      remote_cal_pkg::CMD_CHAN_A_GAUGE:  mnem = 24'h534100;
      remote_cal_pkg::CMD_CHAN_B_GAUGE:  mnem = 24'h534200;
      remote_cal_pkg::CMD_GAUGE_ROLL:    mnem = 24'h535600;
      remote_cal_pkg::CMD_GAUGE_PICK:    mnem = 24'h535300;
      remote_cal_pkg::CMD_GAUGE_REMOVE:  mnem = 24'h534400;
      remote_cal_pkg::CMD_TEDS_QUERY:    mnem = 24'h535400;
      remote_cal_pkg::CMD_SHUNT_VERIFY:  mnem = 24'h434300;
      remote_cal_pkg::CMD_CALIB_ID:      mnem = 24'h434231;
      remote_cal_pkg::CMD_CALIB_DATE:    mnem = 24'h434232;
      remote_cal_pkg::CMD_CALIB_DRIVE:   mnem = 24'h434233;
      remote_cal_pkg::CMD_CALIB_RATING:  mnem = 24'h434234;
      remote_cal_pkg::CMD_CALIB_ABORT:   mnem = 24'h434500;
      remote_cal_pkg::CMD_ONE_POINT_MVV: mnem = 24'h435600;
      remote_cal_pkg::CMD_WEIGHT_POINTS: mnem = 24'h434D00;
      remote_cal_pkg::CMD_TORQUE_POINTS: mnem = 24'h435400;
      remote_cal_pkg::CMD_SHUNT_CAL:     mnem = 24'h435300;
      default:                           mnem = 24'h000000;
    endcase
  endfunction

  // character classes used by several checks
  function automatic logic is_dig(input logic [7:0] c);
    is_dig = (c >= remote_cal_pkg::CH_0) && (c <= remote_cal_pkg::CH_9);
  endfunction
  function automatic logic is_chan(input logic [7:0] c);
    is_chan = (c == remote_cal_pkg::CH_A) || (c == remote_cal_pkg::CH_B);
  endfunction

  logic [23:0]         dev_addr_q;
  logic [7:0]          arg_q [DEPTH];
  logic [4:0]          arg_len_q;
  remote_cal_pkg::cmd_t cmd_q;
  remote_cal_pkg::tx_state_t st_q;
  logic [2:0]          stage_q;
  logic                cell_type_q, remap_q, refused_q, pfx_err_q, cal_chan_q;
  logic [5:0]          pos_q;
  logic [9:0]          tx_sh_q;
  logic [3:0]          tx_bits_q;
  logic [15:0]         baud_q;
  logic [29:0]         hold_q;
  logic [31:0]         rdata_q;

  // register decode
  wire sel_ctrl = wr_i && (addr_i == remote_cal_pkg::OFS_CTRL);
  wire sel_addr = wr_i && (addr_i == remote_cal_pkg::OFS_ADDR);
  wire sel_arg  = wr_i && (addr_i == remote_cal_pkg::OFS_ARG);
  wire rd_rx    = rd_i && (addr_i == remote_cal_pkg::OFS_RX);
  wire go       = sel_ctrl && wdata_i[remote_cal_pkg::CTRL_GO];
  wire clr_stk  = sel_ctrl && wdata_i[remote_cal_pkg::CTRL_CLEAR];
  wire no_load  = wdata_i[remote_cal_pkg::CTRL_NO_LOAD];
  remote_cal_pkg::cmd_t new_cmd;
  assign new_cmd = remote_cal_pkg::cmd_t'(wdata_i[4:0]);

  // per-position character checks over the argument buffer
  logic [DEPTH-1:0] num_ok, dig_ok;
  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++) begin : g_chk
      wire out_rng = (5'(gi) >= arg_len_q);
      assign dig_ok[gi] = out_rng || is_dig(arg_q[gi]);
      assign num_ok[gi] = out_rng || is_dig(arg_q[gi])
                       || arg_q[gi] == remote_cal_pkg::CH_DOT
                       || arg_q[gi] == remote_cal_pkg::CH_MIN
                       || arg_q[gi] == remote_cal_pkg::CH_PLUS;
    end
  endgenerate

  wire lead_sp = (arg_q[0] == remote_cal_pkg::CH_SP);
  wire len0    = (arg_len_q == 5'd0);
  wire len1    = (arg_len_q == 5'd1);
  wire ok_id   = (lead_sp || arg_q[0] == remote_cal_pkg::CH_0
                 || arg_q[0] == remote_cal_pkg::CH_1)
              && is_chan(arg_q[1]) && arg_len_q >= 5'd3
              && arg_len_q <= 5'(remote_cal_pkg::SERIAL_MAX + 2);
  wire ok_date = lead_sp && (&(dig_ok | 16'h0001))
              && arg_len_q == 5'(remote_cal_pkg::DATE_LEN);
  wire ok_drv  = lead_sp && arg_len_q == 5'(remote_cal_pkg::DRIVE_LEN)
              && (arg_q[1] == remote_cal_pkg::CH_0
                  || arg_q[1] == remote_cal_pkg::CH_1)
              && is_dig(arg_q[2]);
  wire ok_rate = lead_sp && arg_len_q > 5'd1
              && (&(num_ok | 16'h0001));
  wire ok_num  = !len0 && (&num_ok);
  wire cal_rdy = (stage_q == 3'd4);

  // format and sequence check of the ordered command
  logic cmd_ok;
  always_comb begin
    case (new_cmd)
      remote_cal_pkg::CMD_OUTPUT_QUERY,
      remote_cal_pkg::CMD_CHAN_A_GAUGE,
      remote_cal_pkg::CMD_CHAN_B_GAUGE,
      remote_cal_pkg::CMD_GAUGE_ROLL,
      remote_cal_pkg::CMD_CALIB_ABORT:   cmd_ok = len0;
      remote_cal_pkg::CMD_OUTPUT_CONFIG: cmd_ok = arg_len_q >= 5'd4;
      remote_cal_pkg::CMD_GAUGE_PICK:
        cmd_ok = is_chan(arg_q[0]) && arg_len_q >= 5'd2;
      remote_cal_pkg::CMD_GAUGE_REMOVE:  cmd_ok = !len0;
      remote_cal_pkg::CMD_TEDS_QUERY:
        cmd_ok = len1 && is_chan(arg_q[0]);
      remote_cal_pkg::CMD_SHUNT_VERIFY:
        cmd_ok = len1 && is_chan(arg_q[0]) && no_load;
      remote_cal_pkg::CMD_CALIB_ID:      cmd_ok = ok_id;
      remote_cal_pkg::CMD_CALIB_DATE:    cmd_ok = ok_date && stage_q == 3'd1;
      remote_cal_pkg::CMD_CALIB_DRIVE:   cmd_ok = ok_drv && stage_q == 3'd2;
      remote_cal_pkg::CMD_CALIB_RATING:  cmd_ok = ok_rate && stage_q == 3'd3;
      remote_cal_pkg::CMD_ONE_POINT_MVV,
      remote_cal_pkg::CMD_SHUNT_CAL:     cmd_ok = ok_num && cal_rdy;
      remote_cal_pkg::CMD_WEIGHT_POINTS,
      remote_cal_pkg::CMD_TORQUE_POINTS:
        cmd_ok = len1 && is_dig(arg_q[0]) && cal_rdy;
      default:                           cmd_ok = 1'b0;
    endcase
  end
  wire accept = go && (st_q == remote_cal_pkg::ST_IDLE) && cmd_ok;

  // frame layout: '@', address, mnemonic, arguments, optional '#', CR
  wire [23:0] mn    = mnem(cmd_q);
  wire [5:0]  mlen  = (mn[7:0] == 8'h00) ? 6'd2 : 6'd3;
  wire        hash  = (cmd_q == remote_cal_pkg::CMD_OUTPUT_CONFIG)
                   || (cmd_q == remote_cal_pkg::CMD_GAUGE_PICK)
                   || (cmd_q == remote_cal_pkg::CMD_GAUGE_REMOVE)
                   || (cmd_q == remote_cal_pkg::CMD_CALIB_ID)
                   || (cmd_q == remote_cal_pkg::CMD_CALIB_RATING)
                   || (cmd_q == remote_cal_pkg::CMD_ONE_POINT_MVV)
                   || (cmd_q == remote_cal_pkg::CMD_SHUNT_CAL);
  wire [5:0]  arg_e = 6'd4 + mlen + {1'b0, arg_len_q};
  wire [5:0]  f_len = arg_e + {5'd0, hash} + 6'd1;
  wire [5:0]  m_ix  = pos_q - 6'd4;
  wire [5:0]  a_ix  = pos_q - 6'd4 - mlen;
  wire [5:0]  d_ix  = 6'd3 - pos_q;
  logic [7:0] tx_byte;
  assign tx_byte =
      (pos_q == 6'd0) ? remote_cal_pkg::CH_AT :
      (pos_q < 6'd4)  ? dev_addr_q[8*(d_ix[1:0]) +: 8] :
      (pos_q < 6'd4 + mlen) ? mn[8*(2'd2 - m_ix[1:0]) +: 8] :
      (pos_q < arg_e) ? arg_q[a_ix[3:0]] :
      (hash && pos_q == arg_e) ? remote_cal_pkg::CH_HASH :
      remote_cal_pkg::CH_CR;
  wire bit_end = (baud_q == 16'(BIT_CYCLES - 1));

  // software-written registers and command acceptance
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dev_addr_q <= remote_cal_pkg::ADDR_RST;
      arg_len_q  <= 5'd0;
      cmd_q      <= remote_cal_pkg::CMD_OUTPUT_QUERY;
    end else begin
      if (sel_addr)
        dev_addr_q <= wdata_i[23:0];
      if (sel_arg && wdata_i[remote_cal_pkg::ARG_CLEAR])
        arg_len_q <= 5'd0;
      else if (sel_arg && arg_len_q < 5'(DEPTH))
        arg_len_q <= arg_len_q + 5'd1;
      if (accept)
        cmd_q <= new_cmd;
    end
  end

  // argument store, no reset needed for data
  always_ff @(posedge mclk_i) begin
    if (sel_arg && !wdata_i[remote_cal_pkg::ARG_CLEAR]
        && arg_len_q < 5'(DEPTH))
      arg_q[arg_len_q[3:0]] <= wdata_i[7:0];
  end

  // calibration sequence tracking and sticky flags
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stage_q     <= 3'd0;
      cell_type_q <= 1'b0;
      cal_chan_q  <= 1'b0;
      remap_q     <= 1'b0;
      refused_q   <= 1'b0;
    end else begin
      if (go && !accept)
        refused_q <= 1'b1;
      else if (clr_stk)
        refused_q <= 1'b0;
      if (accept) begin
        case (new_cmd)
          remote_cal_pkg::CMD_CALIB_ID: begin
            stage_q     <= 3'd1;
            cell_type_q <= (arg_q[0] == remote_cal_pkg::CH_1);
            cal_chan_q  <= (arg_q[1] == remote_cal_pkg::CH_B);
            if (cell_type_q != (arg_q[0] == remote_cal_pkg::CH_1))
              remap_q <= 1'b1;
          end
          remote_cal_pkg::CMD_CALIB_DATE:   stage_q <= 3'd2;
          remote_cal_pkg::CMD_CALIB_DRIVE:  stage_q <= 3'd3;
          remote_cal_pkg::CMD_CALIB_RATING: stage_q <= 3'd4;
          remote_cal_pkg::CMD_CALIB_ABORT:  stage_q <= 3'd0;
          remote_cal_pkg::CMD_OUTPUT_CONFIG: begin
            remap_q <= 1'b0;
            stage_q <= 3'd0;
          end
          default:
            if (new_cmd < remote_cal_pkg::CMD_SHUNT_VERIFY)
              stage_q <= 3'd0;
        endcase
      end
    end
  end

  // frame transmitter and shunt wait
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q      <= remote_cal_pkg::ST_IDLE;
      pos_q     <= 6'd0;
      tx_sh_q   <= remote_cal_pkg::TX_IDLE;
      tx_bits_q <= 4'd0;
      baud_q    <= 16'd0;
      hold_q    <= 30'd0;
    end else begin
      case (st_q)
        remote_cal_pkg::ST_IDLE:
          if (accept) begin
            pos_q <= 6'd0;
            st_q  <= remote_cal_pkg::ST_LOAD;
          end
        remote_cal_pkg::ST_LOAD: begin
          tx_sh_q   <= {1'b1, tx_byte, 1'b0};
          tx_bits_q <= 4'd10;
          baud_q    <= 16'd0;
          pos_q     <= pos_q + 6'd1;
          st_q      <= remote_cal_pkg::ST_SHIFT;
        end
        remote_cal_pkg::ST_SHIFT:
          if (bit_end) begin
            baud_q    <= 16'd0;
            tx_sh_q   <= {1'b1, tx_sh_q[9:1]};
            tx_bits_q <= tx_bits_q - 4'd1;
            if (tx_bits_q == 4'd1) begin
              if (pos_q != f_len)
                st_q <= remote_cal_pkg::ST_LOAD;
              else if (cmd_q == remote_cal_pkg::CMD_SHUNT_VERIFY) begin
                hold_q <= 30'(SHUNT_CYCLES - 1);
                st_q   <= remote_cal_pkg::ST_HOLD;
              end else
                st_q <= remote_cal_pkg::ST_IDLE;
            end
          end else
            baud_q <= baud_q + 16'd1;
        remote_cal_pkg::ST_HOLD:
          if (hold_q == 30'd0)
            st_q <= remote_cal_pkg::ST_IDLE;
          else
            hold_q <= hold_q - 30'd1;
        default: st_q <= remote_cal_pkg::ST_IDLE;
      endcase
    end
  end
  assign txd_o = tx_sh_q[0];

  // receiver: three-stage sync, level accepted when stages two and three agree
  logic       rs1_q, rs2_q, rs3_q, rlvl_q, rbusy_q, rvalid_q;
  logic [15:0] rcnt_q;
  logic [3:0]  rbit_q;
  logic [8:0]  rsh_q;
  logic [7:0]  rbyte_q;
  logic [2:0]  rpos_q;
  wire r_lvl    = (rs2_q == rs3_q) ? rs2_q : rlvl_q;
  wire r_sample = rbusy_q && (rcnt_q == 16'(BIT_CYCLES - 1));
  wire r_done   = r_sample && (rbit_q == 4'd9);
  wire [7:0] r_data = rsh_q[8:1];
  wire [2:0] rp_ix  = 3'd3 - rpos_q;
  wire [7:0] r_exp  = (rpos_q == 3'd0) ? remote_cal_pkg::CH_AT
                     : dev_addr_q[8*(rp_ix[1:0]) +: 8];
  wire r_eol = (r_data == remote_cal_pkg::CH_CR)
            || (r_data == remote_cal_pkg::CH_LF);

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {rs1_q, rs2_q, rs3_q, rlvl_q} <= 4'hF;
      rbusy_q <= 1'b0;
      rcnt_q  <= 16'd0;
      rbit_q  <= 4'd0;
      rsh_q   <= 9'd0;
    end else begin
      rs1_q  <= rxd_i;
      rs2_q  <= rs1_q;
      rs3_q  <= rs2_q;
      rlvl_q <= r_lvl;
      if (!rbusy_q && !r_lvl) begin
        rbusy_q <= 1'b1;
        rcnt_q  <= 16'(BIT_CYCLES / 2);    // first sample lands mid-bit
        rbit_q  <= 4'd0;
      end else if (r_sample) begin
        rcnt_q  <= 16'd0;
        rbit_q  <= rbit_q + 4'd1;
        rsh_q   <= {r_lvl, rsh_q[8:1]};
        if (rbit_q == 4'd9 || (rbit_q == 4'd0 && r_lvl))
          rbusy_q <= 1'b0;                 // stop bit or false start
      end else if (rbusy_q)
        rcnt_q <= rcnt_q + 16'd1;
    end
  end

  // reply byte holding, prefix check, read data
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rbyte_q   <= 8'h00;
      rvalid_q  <= 1'b0;
      rpos_q    <= 3'd0;
      pfx_err_q <= 1'b0;
      rdata_q   <= 32'h0000_0000;
    end else begin
      // clears first, so a byte or a mismatch in the same cycle wins
      if (rd_rx)
        rvalid_q <= 1'b0;
      if (clr_stk)
        pfx_err_q <= 1'b0;
      if (r_done && rsh_q[0] == 1'b0 && r_lvl) begin
        rbyte_q  <= r_data;
        rvalid_q <= 1'b1;
        if (r_eol)
          rpos_q <= 3'd0;
        else if (rpos_q < 3'd4) begin
          rpos_q <= rpos_q + 3'd1;
          if (r_data != r_exp)
            pfx_err_q <= 1'b1;
        end
      end
      if (rd_i) begin
        case (addr_i)
          remote_cal_pkg::OFS_CTRL: rdata_q <= {27'd0, cmd_q};
          remote_cal_pkg::OFS_ADDR: rdata_q <= {8'd0, dev_addr_q};
          remote_cal_pkg::OFS_ARG:  rdata_q <= {27'd0, arg_len_q};
          remote_cal_pkg::OFS_STAT:
            rdata_q <= {22'd0, rvalid_q, cal_chan_q, cell_type_q,
                        pfx_err_q, remap_q, refused_q, stage_q,
                        st_q != remote_cal_pkg::ST_IDLE};
          remote_cal_pkg::OFS_RX:   rdata_q <= {23'd0, rvalid_q, rbyte_q};
          default:                  rdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end
  assign rdata_o = rdata_q;
endmodule

// ===== remote_cal_host_asserts.sv
`timescale 1ns/1ps
// watches the software port and the serial output of the host block
module remote_cal_host_asserts #(
  parameter int BIT_CYCLES = 8
) (
  input wire logic        mclk_i,
  input wire logic        rst_n_i,
  input wire logic [7:0]  addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic        txd_o,
  input wire logic        rxd_i
);
  logic [31:0] lo_q, hi_q;
  logic        srd_q, ref_q;
  wire logic   clr_w = wr_i && addr_i == 8'h00 && wdata_i[10];
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  // run lengths on the line, and the refused flag last read back
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lo_q  <= '0;
      hi_q  <= 32'(BIT_CYCLES);
      srd_q <= 1'b0;
      ref_q <= 1'b0;
    end else begin
      lo_q  <= txd_o ? '0 : lo_q + 32'h1;
      hi_q  <= txd_o ? hi_q + 32'h1 : '0;
      srd_q <= rd_i && addr_i == remote_cal_pkg::OFS_STAT;
      ref_q <= clr_w ? 1'b0 : (srd_q ? rdata_o[4] : ref_q);
    end
  end
  // a read, and a write followed at once by a read of the same place
  sequence rd_at(logic [7:0] a);
    rd_i && addr_i == a;
  endsequence
  sequence wr_then_rd(logic [7:0] a, logic c);
    wr_i && c && addr_i == a ##1 rd_at(a);
  endsequence
  idle_reset_a: assert property ($rose(rst_n_i) |-> txd_o)
    else $error("serial line not idle after reset");
  read_hold_a: assert property (!rd_i |=> $stable(rdata_o))
    else $error("read data moved without a read");
  unmapped_a: assert property (rd_i && !(addr_i inside
    {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10}) |=> rdata_o == '0)
    else $error("unmapped read not zero");
  stat_range_a: assert property (rd_at(remote_cal_pkg::OFS_STAT)
    |=> rdata_o[31:10] == '0 && rdata_o[3:1] <= 3'd4)
    else $error("status word out of range");
  addr_back_a: assert property (wr_then_rd(8'h04, 1'b1)
    |=> rdata_o == ($past(wdata_i, 2) & 32'h00FF_FFFF))
    else $error("address readback wrong");
  arg_clear_a: assert property (wr_then_rd(8'h08, wdata_i[8])
    |=> rdata_o == '0)
    else $error("argument length not cleared");
  rx_clear_a: assert property (rd_at(8'h10) ##1 rd_at(8'h10)
    |=> !rdata_o[8])
    else $error("receive valid not cleared by read");
  low_run_a: assert property ($rose(txd_o)
    |-> lo_q % BIT_CYCLES == 0 && lo_q <= 9 * BIT_CYCLES)
    else $error("low run on line not whole bits");
  stop_gap_a: assert property ($fell(txd_o) |-> hi_q >= BIT_CYCLES)
    else $error("stop bit too short");
  refused_keep_a: assert property (srd_q && ref_q |-> rdata_o[4])
    else $error("refused flag dropped without clear");
endmodule
bind remote_cal_host remote_cal_host_asserts #(.BIT_CYCLES(BIT_CYCLES)) chk (
  .mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .txd_o(txd_o), .rxd_i(rxd_i)
);

// ===== remote_dev_model.sv
`timescale 1ns/1ps
// device end of the link: keeps each line, answers it with its prefix, or with address 002 while bad_i is high
module remote_dev_model #(
  parameter int BIT_CYCLES = 8
) (
  input  wire logic mclk_i,
  input  wire logic line_i,
  input  wire logic bad_i,
  output logic      line_o
);
  logic [7:0] frm_q[$];
  int         replies = 0;
  // one byte, lowest bit first, then a long idle high
  task automatic put(input logic [7:0] b);
    line_o <= 1'b0;
    repeat (BIT_CYCLES) @(posedge mclk_i);
    for (int i = 0; i < 8; i++) begin
      line_o <= b[i];
      repeat (BIT_CYCLES) @(posedge mclk_i);
    end
    line_o <= 1'b1;
    repeat (2 * BIT_CYCLES) @(posedge mclk_i);
  endtask
  // sample mid-bit; a line end for this unit triggers the answer
  initial begin
    logic [7:0] b;
    line_o = 1'b1;
    forever begin
      @(negedge line_i);
      repeat (BIT_CYCLES / 2) @(posedge mclk_i);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYCLES) @(posedge mclk_i);
        b[i] = line_i;
      end
      repeat (BIT_CYCLES) @(posedge mclk_i);
      frm_q.push_back(b);
      if (b == 8'h0D && frm_q[0] == 8'h40 && frm_q[3] == 8'h31) begin
        put(8'h40);
        put(8'h30);
        put(8'h30);
        put(bad_i ? 8'h32 : 8'h31);
        put(8'h0D);
        replies++;
      end
    end
  end
endmodule

// ===== remote_setup_calib_cmds_tb_top.sv
`timescale 1ns/1ps
// drives the host block through its software port against the device model
module remote_setup_calib_cmds_tb_top;
  logic        mclk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [7:0]  addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic        bad_q = 1'b0;
  logic [31:0] rdata_o;
  logic        txd_o;
  logic        rxd_w;
  int          fails = 0;
  int          checks_done = 0;
  remote_cal_host #(.BIT_CYCLES(8), .SHUNT_CYCLES(20)) uut (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .txd_o(txd_o), .rxd_i(rxd_w)
  );
  remote_dev_model #(.BIT_CYCLES(8)) dev (
    .mclk_i(mclk_i), .line_i(txd_o), .bad_i(bad_q), .line_o(rxd_w)
  );
  // system clock
  initial forever #5 mclk_i = ~mclk_i;
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one-cycle write strobe on the software port; a read comes after two reads of address FF
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] s);
    pair(1'b0, 8'hFF, 32'h0, s);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 s = rdata_o;
  endtask
  // write or read, then at once a read of the same place
  task automatic pair(input bit w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] s);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= w;
    rd_i <= !w;
    @(posedge mclk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 s = rdata_o;
  endtask
  task automatic stat(input logic [31:0] m, input logic [31:0] e);
    logic [31:0] s;
    pair(1'b0, remote_cal_pkg::OFS_STAT, 32'h0, s);
    check(s & m, e);
  endtask
  task automatic launch(input logic [4:0] c, input string s, input bit nl);
    wr(remote_cal_pkg::OFS_ARG, 32'h100);
    foreach (s[i]) wr(remote_cal_pkg::OFS_ARG, {24'h0, s[i]});
    dev.frm_q.delete();
    wr(remote_cal_pkg::OFS_CTRL, {22'h0, nl, 1'b1, 3'h0, c});
  endtask
  // wait for the answer, then compare the whole sent line
  task automatic finish(input logic [23:0] mn, input string s, input bit h);
    logic [7:0] e[$];
    int n;
    e = {8'h40, 8'h30, 8'h30, 8'h31};
    for (int i = 16; i >= 0; i -= 8)
      if (mn[i+:8] != 8'h0)
        e.push_back(mn[i+:8]);
    foreach (s[i]) e.push_back(s[i]);
    if (h) e.push_back(8'h23);
    e.push_back(8'h0D);
    n = dev.replies;
    for (int k = 0; k < 20000 && dev.replies == n; k++) @(posedge mclk_i);
    if (dev.replies == n) begin
      fails++;
      $display("FAIL %0t no reply from device", $time);
      final_report();
    end
    check(dev.frm_q.size(), e.size());
    foreach (e[i]) check(dev.frm_q[i], e[i]);
  endtask
  task automatic run(input logic [4:0] c, input logic [23:0] mn,
                     input string s, input bit h);
    launch(c, s, 1'b1);
    finish(mn, s, h);
  endtask
  // a refused order sends nothing and raises the sticky flag
  task automatic refuse(input logic [4:0] c, input string s, input bit nl);
    int lo;
    lo = 0;
    wr(remote_cal_pkg::OFS_CTRL, 32'h400);
    launch(c, s, nl);
    repeat (12) begin
      @(posedge mclk_i);
      lo += !txd_o;
    end
    check(lo, 0);
    stat(32'h11, 32'h10);
  endtask
  task automatic t_regs();
    logic [31:0] s;
    stat(32'hFFFF_FFFF, 32'h0);
    rd(remote_cal_pkg::OFS_ADDR, s);
    check(s, {8'h0, remote_cal_pkg::ADDR_RST});
    wr(8'h24, 32'hFFFF);
    rd(8'h24, s);
    check(s, 32'h0);
    pair(1'b1, remote_cal_pkg::OFS_ADDR, 32'hAA30_3031, s);
    check(s, 32'h0030_3031);
    pair(1'b1, remote_cal_pkg::OFS_ARG, 32'h41, s);
    check(s, 32'h1);
    pair(1'b1, remote_cal_pkg::OFS_ARG, 32'h100, s);
    check(s, 32'h0);
    $display("test registers done");
  endtask
  task automatic t_output();
    logic [31:0] s;
    run(5'd0, 24'h4156, "", 1'b0);
    rd(remote_cal_pkg::OFS_RX, s);
    check(s, 32'h10D);
    run(5'd1, 24'h4153, "090010.0#5.0", 1'b1);
    pair(1'b0, remote_cal_pkg::OFS_RX, 32'h0, s);
    check(s & 32'h100, 32'h0);
    $display("test output done");
  endtask
  task automatic t_refuse();
    for (int c = 14; c <= 17; c++) refuse(5'(c), "5", 1'b1);
    refuse(5'd8, "A", 1'b0);
    stat(32'h10, 32'h10);
    wr(remote_cal_pkg::OFS_CTRL, 32'h400);
    stat(32'h10, 32'h0);
    $display("test refusals done");
  endtask
  task automatic t_calib();
    run(5'd9, 24'h434231, " A12", 1'b1);
    stat(32'h1AE, 32'h2);
    run(5'd10, 24'h434232, " 042298", 1'b0);
    stat(32'hE, 32'h4);
    run(5'd11, 24'h434233, " 10", 1'b0);
    stat(32'hE, 32'h6);
    run(5'd12, 24'h434234, " 1000.0", 1'b1);
    run(5'd14, 24'h4356, "-4.5", 1'b1);
    run(5'd15, 24'h434D, "5", 1'b0);
    run(5'd16, 24'h4354, "2", 1'b0);
    run(5'd17, 24'h4353, "49.5", 1'b1);
    stat(32'h1E, 32'h8);
    run(5'd9, 24'h434231, " A12", 1'b1);
    stat(32'hE, 32'h2);
    run(5'd13, 24'h4345, "", 1'b0);
    stat(32'hE, 32'h0);
    run(5'd9, 24'h434231, "1B7", 1'b1);
    stat(32'h1AE, 32'h1A2);
    run(5'd4, 24'h5356, "", 1'b0);
    stat(32'hE, 32'h0);
    run(5'd1, 24'h4153, "000010.0#0.0", 1'b1);
    stat(32'h20, 32'h0);
    $display("test calibration done");
  endtask
  task automatic t_sensor();
    run(5'd2, 24'h5341, "", 1'b0);
    run(5'd3, 24'h5342, "", 1'b0);
    run(5'd5, 24'h5353, "A12", 1'b1);
    run(5'd6, 24'h5344, "12", 1'b1);
    run(5'd7, 24'h5354, "B", 1'b0);
    launch(5'd8, "A", 1'b1);
    for (int k = 0; k < 2000 && dev.frm_q.size() < 8; k++) @(posedge mclk_i);
    check(32'(dev.frm_q.size()), 32'd8);
    repeat (10) @(posedge mclk_i);
    stat(32'h1, 32'h1);
    finish(24'h4343, "A", 1'b0);
    bad_q <= 1'b1;
    run(5'd0, 24'h4156, "", 1'b0);
    stat(32'h40, 32'h40);
    bad_q <= 1'b0;
    $display("test sensor and prefix done");
  endtask
  initial begin
    repeat (20) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    t_regs();
    t_output();
    t_refuse();
    t_calib();
    t_sensor();
    final_report();
  end
endmodule
